// [verilog/chgh_defs.svh]
`ifndef CHGH_DEFS_SVH
`define CHGH_DEFS_SVH
// Functional notes
// - slave only, 7-bit address 6A, D4 with direction bit
// - standard and fast rate, same protocol; master stays within fast rate
// - data low past hang timeout ignores commands and resets engine
// - hang timer restarts on start and repeated start, stops at stop
// - on address match only, hold data low through ninth clock high
// - direction 0 master writes, direction 1 device returns bytes
// - receiver acknowledges every byte, any number of bytes
// - reads outside the register map return all ones
// - input overvoltage: flag, fault, pulse, power not good, charge off
// - input undervoltage: flag, fault, pulse, power not good, charge off
// - input current limit: charging status, pulse, keep charging limited
// - battery undervoltage: flag, fault, pulse, force pre-charge
// - safety timer expiry: flag, fault, pulse, charge and sensing off
// - input power management: active flag, fault, pulse, reduced current
// - cold or hot: thermistor field, fault, pulse, suspend charging
// - cool: thermistor field, fault, pulse, halve charge current
// - warm: thermistor field, fault, pulse, lower regulation target
// - charge done: status, pulse, stop until below recharge threshold
// - status 00 ready, 01 charging, 10 done, 11 fault, present only
// - each notification is one low pulse of fixed length
`define CHGH_CLK_NS 5
`define CHGH_INT_PULSE_NS 128000
`define CHGH_HANG_NS 25000000
`define CHGH_DEV_ADDR 7'h6A
`define CHGH_R_STAT 8'h00
`define CHGH_R_FAULT 8'h01
`define CHGH_R_TS 8'h02
`define CHGH_R_FC 8'h03
`define CHGH_TS_RST 8'h88
`define CHGH_FC_RST 8'h14
`define CHGH_SHIP_BIT 5
`define CHGH_CE_BIT 1
`define CHGH_HZ_BIT 0
`define CHGH_ST_READY 2'h0
`define CHGH_ST_CHG 2'h1
`define CHGH_ST_DONE 2'h2
`define CHGH_ST_FAULT 2'h3
`define CHGH_TS_NORM 2'h0
`define CHGH_TS_COLDHOT 2'h1
`define CHGH_TS_COOL 2'h2
`define CHGH_TS_WARM 2'h3
`define CHGH_A_STATUS 8'h00
`define CHGH_A_CONFIG 8'h04
`endif

// [verilog/chgh_pkg.sv]
package chgh_pkg;
    typedef struct packed {
        logic input_overvoltage_flag;
        logic input_undervoltage_flag;
        logic input_current_limit_event;
        logic battery_undervoltage_flag;
        logic timer_expired;
        logic input_power_management_active;
        logic [1:0] thermistor_fault_field;
        logic charge_done;
        logic below_recharge_threshold;
    } chgh_cond_t;
    typedef struct packed {
        logic power_good_output;
        logic charge_enable;
        logic thermistor_sense_en;
        logic system_output_from_battery;
        logic precharge_force;
        logic charge_current_half;
        logic battery_regulation_lower;
        logic input_current_limited;
        logic input_current_reduced;
        logic recharge_monitor;
    } chgh_ctrl_t;
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_RX, I2C_RACK, I2C_TX, I2C_TACK
    } chgh_i2c_st_t;
endpackage

// [verilog/chgh_top.sv]
`include "chgh_defs.svh"
module chgh_top #(
    parameter int INT_CYC = `CHGH_INT_PULSE_NS / `CHGH_CLK_NS,
    parameter int HANG_CYC = `CHGH_HANG_NS / `CHGH_CLK_NS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire chgh_pkg::chgh_cond_t cond_i,
    output chgh_pkg::chgh_ctrl_t ctrl_o,
    output logic int_n
);
    localparam int HW = $clog2(HANG_CYC + 1);
    localparam int IW = $clog2(INT_CYC + 1);

    generate
        if (INT_CYC < 2 || HANG_CYC < 2) begin : g_bad
            $error("pulse and hang counts must be at least 2");
        end
    endgenerate

    // pins, two flops each before use
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d;
    chgh_pkg::chgh_cond_t cm_q, cs_q, cp_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cm_q <= '0;
            cs_q <= '0;
            cp_q <= '0;
        end else begin
            cm_q <= cond_i;
            cs_q <= cm_q;
            cp_q <= cs_q;
        end
    end

    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
    assign scl = scl_s[1];
    assign sda = sda_s[1];
    // edges are found by sampling, so standard and fast rate run the same path
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign start_c = scl && scl_d && sda_d && !sda;
    assign stop_c = scl && scl_d && !sda_d && sda;

    // register state
    logic ship_q, uv_q, tmr_q, done_q, ts_en_q, int_en_q;
    logic [3:0] fmask_q;
    logic [2:0] tmask_q;
    logic [7:0] fc_q;
    logic [1:0] stat_q;
    logic inactive;
    assign inactive = ship_q || fc_q[`CHGH_HZ_BIT];

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        case (a)
            `CHGH_R_STAT: rd_byte = {stat_q, 1'b0, 1'b0, tmr_q,
                cs_q.input_power_management_active, 1'b0, 1'b1};
            `CHGH_R_FAULT: rd_byte = {cs_q.input_overvoltage_flag, uv_q,
                cs_q.battery_undervoltage_flag, 1'b0, fmask_q};
            `CHGH_R_TS: rd_byte = {ts_en_q, cs_q.thermistor_fault_field,
                1'b0, int_en_q, tmask_q};
            `CHGH_R_FC: rd_byte = fc_q;
            default: rd_byte = 8'hFF;
        endcase
    endfunction

    // serial engine
    chgh_pkg::chgh_i2c_st_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q, wadr_q, wdat_q;
    logic rw_q, first_q, oe_q, nack_q, wr_q, rdclr_q, hang_hit;
    logic [HW-1:0] hcnt_q;
    logic [7:0] nxt;
    // always_comb so that status changes behind a fixed pointer are seen too
    always_comb begin
        nxt = rd_byte(ptr_q);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= chgh_pkg::I2C_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            wadr_q <= 8'h00;
            wdat_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            oe_q <= 1'b0;
            nack_q <= 1'b0;
            wr_q <= 1'b0;
            rdclr_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rdclr_q <= 1'b0;
            if (hang_hit) begin
                st_q <= chgh_pkg::I2C_IDLE;
                oe_q <= 1'b0;
            end else if (start_c) begin
                st_q <= chgh_pkg::I2C_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= chgh_pkg::I2C_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (st_q)
                    chgh_pkg::I2C_ADDR: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            if (sh_q[7:1] == `CHGH_DEV_ADDR && !inactive) begin
                                st_q <= chgh_pkg::I2C_AACK;
                                oe_q <= 1'b1;
                                rw_q <= sh_q[0];
                            end else begin
                                st_q <= chgh_pkg::I2C_IDLE;
                            end
                        end
                    end
                    chgh_pkg::I2C_AACK: begin
                        if (scl_fall) begin
                            cnt_q <= 4'h0;
                            if (rw_q) begin
                                st_q <= chgh_pkg::I2C_TX;
                                sh_q <= nxt;
                                oe_q <= !nxt[7];
                                rdclr_q <= (ptr_q == `CHGH_R_FAULT);
                            end else begin
                                st_q <= chgh_pkg::I2C_RX;
                                oe_q <= 1'b0;
                                first_q <= 1'b1;
                            end
                        end
                    end
                    chgh_pkg::I2C_RX: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            st_q <= chgh_pkg::I2C_RACK;
                            oe_q <= 1'b1;
                            first_q <= 1'b0;
                            if (first_q) begin
                                ptr_q <= sh_q;
                            end else begin
                                wr_q <= 1'b1;
                                wadr_q <= ptr_q;
                                wdat_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                    chgh_pkg::I2C_RACK: begin
                        if (scl_fall) begin
                            st_q <= chgh_pkg::I2C_RX;
                            oe_q <= 1'b0;
                            cnt_q <= 4'h0;
                        end
                    end
                    chgh_pkg::I2C_TX: begin
                        if (scl_fall) begin
                            if (cnt_q == 4'h7) begin
                                st_q <= chgh_pkg::I2C_TACK;
                                oe_q <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                oe_q <= !sh_q[6];
                                sh_q <= {sh_q[6:0], 1'b0};
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    chgh_pkg::I2C_TACK: begin
                        if (scl_rise) begin
                            nack_q <= sda;
                        end else if (scl_fall) begin
                            cnt_q <= 4'h0;
                            if (nack_q) begin
                                st_q <= chgh_pkg::I2C_IDLE;
                            end else begin
                                st_q <= chgh_pkg::I2C_TX;
                                sh_q <= nxt;
                                oe_q <= !nxt[7];
                                rdclr_q <= (ptr_q == `CHGH_R_FAULT);
                            end
                        end
                    end
                    default: begin
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;

    // only consecutive data-low time counts; a slow master is cut off only if data stays low that long
    assign hang_hit = st_q != chgh_pkg::I2C_IDLE && !sda
        && hcnt_q == HW'(HANG_CYC - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_q <= '0;
        end else if (start_c || sda || st_q == chgh_pkg::I2C_IDLE) begin
            hcnt_q <= '0;
        end else if (!hang_hit) begin
            hcnt_q <= hcnt_q + HW'(1);
        end
    end

    // serial-side and bus-side register writes
    logic apb_wr, wake_clr;
    assign apb_wr = psel && penable && pwrite;
    assign wake_clr = apb_wr && paddr == `CHGH_A_CONFIG && pwdata[0];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ship_q <= 1'b0;
            fmask_q <= 4'h0;
            ts_en_q <= 1'(`CHGH_TS_RST >> 7);
            int_en_q <= 1'(`CHGH_TS_RST >> 3);
            tmask_q <= 3'h0;
            fc_q <= `CHGH_FC_RST;
        end else begin
            if (wake_clr) begin
                ship_q <= 1'b0;
            end
            if (wr_q) begin
                case (wadr_q)
                    `CHGH_R_STAT: begin
                        if (wdat_q[`CHGH_SHIP_BIT]) begin
                            ship_q <= 1'b1;
                        end
                    end
                    `CHGH_R_FAULT: fmask_q <= wdat_q[3:0];
                    `CHGH_R_TS: begin
                        ts_en_q <= wdat_q[7];
                        int_en_q <= wdat_q[3];
                        tmask_q <= wdat_q[2:0];
                    end
                    `CHGH_R_FC: fc_q <= wdat_q;
                    default: begin
                    end
                endcase
            end
        end
    end

    // condition events
    logic ev_ov, ev_uv, ev_bu, ev_tm, ev_dpm, ev_il, ev_ts, ev_dn;
    assign ev_ov = cs_q.input_overvoltage_flag && !cp_q.input_overvoltage_flag;
    assign ev_uv = cs_q.input_undervoltage_flag && !cp_q.input_undervoltage_flag;
    assign ev_bu = cs_q.battery_undervoltage_flag
        && !cp_q.battery_undervoltage_flag;
    assign ev_tm = cs_q.timer_expired && !cp_q.timer_expired;
    assign ev_dpm = cs_q.input_power_management_active
        && !cp_q.input_power_management_active;
    assign ev_il = cs_q.input_current_limit_event
        && !cp_q.input_current_limit_event;
    assign ev_ts = cs_q.thermistor_fault_field != cp_q.thermistor_fault_field
        && cs_q.thermistor_fault_field != `CHGH_TS_NORM;
    assign ev_dn = cs_q.charge_done && !cp_q.charge_done;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            uv_q <= 1'b0;
            tmr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            // set beats the read clear
            uv_q <= ev_uv || (uv_q && !rdclr_q);
            tmr_q <= ev_tm || (tmr_q && !ev_uv);
            if (ev_dn) begin
                done_q <= 1'b1;
            end else if (cs_q.below_recharge_threshold) begin
                done_q <= 1'b0;
            end
        end
    end

    // charger responses
    logic vin_bad, fault_any, ts_ok;
    assign vin_bad = cs_q.input_overvoltage_flag || cs_q.input_undervoltage_flag;
    assign ts_ok = cs_q.thermistor_fault_field != `CHGH_TS_COLDHOT || !ts_en_q;
    assign fault_any = vin_bad || cs_q.battery_undervoltage_flag || tmr_q
        || cs_q.input_power_management_active
        || cs_q.thermistor_fault_field != `CHGH_TS_NORM;
    chgh_pkg::chgh_ctrl_t ctrl_d;
    always_comb begin
        ctrl_d = '0;
        ctrl_d.power_good_output = !vin_bad;
        ctrl_d.charge_enable = !vin_bad && !tmr_q && ts_ok && !done_q
            && !fc_q[`CHGH_CE_BIT] && !inactive;
        ctrl_d.thermistor_sense_en = ts_en_q && !vin_bad && !tmr_q;
        ctrl_d.system_output_from_battery = vin_bad;
        ctrl_d.precharge_force = cs_q.battery_undervoltage_flag;
        ctrl_d.charge_current_half =
            cs_q.thermistor_fault_field == `CHGH_TS_COOL;
        ctrl_d.battery_regulation_lower =
            cs_q.thermistor_fault_field == `CHGH_TS_WARM;
        ctrl_d.input_current_limited = cs_q.input_current_limit_event;
        ctrl_d.input_current_reduced =
            cs_q.input_power_management_active;
        ctrl_d.recharge_monitor = done_q;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_o <= '0;
            stat_q <= `CHGH_ST_READY;
        end else begin
            ctrl_o <= ctrl_d;
            if (fault_any) begin
                stat_q <= `CHGH_ST_FAULT;
            end else if (done_q) begin
                stat_q <= `CHGH_ST_DONE;
            end else if (ctrl_d.charge_enable) begin
                stat_q <= `CHGH_ST_CHG;
            end else begin
                stat_q <= `CHGH_ST_READY;
            end
        end
    end

    // one fixed low pulse; events during a pulse leave one more pending
    logic ev_any, pend_q;
    logic [IW-1:0] icnt_q;
    assign ev_any = !inactive && ((ev_ov && !fmask_q[3]) || (ev_uv && !fmask_q[2])
        || (ev_bu && !fmask_q[1]) || (ev_tm && !tmask_q[0]) || ev_dpm || ev_ts
        || (int_en_q && (ev_il || ev_dn)));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_n <= 1'b1;
            pend_q <= 1'b0;
            icnt_q <= '0;
        end else if (!int_n) begin
            pend_q <= pend_q || ev_any;
            if (icnt_q == IW'(INT_CYC - 1)) begin
                int_n <= 1'b1;
                icnt_q <= '0;
            end else begin
                icnt_q <= icnt_q + IW'(1);
            end
        end else if (ev_any || pend_q) begin
            int_n <= 1'b0;
            pend_q <= 1'b0;
        end
    end

    // bus slave, zero wait states
    logic apb_hit;
    assign apb_hit = paddr == `CHGH_A_STATUS || paddr == `CHGH_A_CONFIG;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (paddr == `CHGH_A_STATUS) begin
                prdata <= {12'h000, st_q, uv_q, tmr_q, done_q, ship_q,
                    fc_q[`CHGH_HZ_BIT], stat_q, ctrl_o};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_addr_ok;
        st_q == chgh_pkg::I2C_ADDR && scl_fall && cnt_q == 4'h8 && !start_c
            && !stop_c && !hang_hit && sh_q[7:1] == `CHGH_DEV_ADDR;
    endsequence
    property p_ack_addr;
        s_addr_ok ##0 !inactive |=> sda_oe && st_q == chgh_pkg::I2C_AACK;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("no address ack");
    property p_quiet;
        inactive |=> st_q != chgh_pkg::I2C_AACK || $past(st_q) == chgh_pkg::I2C_AACK;
    endproperty
    a_quiet: assert property (p_quiet) else $error("ack while inactive");
    property p_hang;
        hang_hit |=> st_q == chgh_pkg::I2C_IDLE && !sda_oe;
    endproperty
    a_hang: assert property (p_hang) else $error("hang not reset");
    property p_start;
        start_c |=> hcnt_q == '0 && st_q == chgh_pkg::I2C_ADDR;
    endproperty
    a_start: assert property (p_start) else $error("start no restart");
    property p_int_len;
        $rose(int_n) |-> $past(icnt_q) == IW'(INT_CYC - 1);
    endproperty
    a_int_len: assert property (p_int_len) else $error("bad pulse length");
    property p_fault;
        fault_any |=> stat_q == `CHGH_ST_FAULT;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not shown");
    property p_ov;
        cs_q.input_overvoltage_flag |=> !ctrl_o.power_good_output
            && !ctrl_o.charge_enable && ctrl_o.system_output_from_battery;
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage response");
    property p_uv_flag;
        ev_uv |=> uv_q ##1 (uv_q || $past(rdclr_q));
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("uv flag lost");
    property p_ff;
        $rose(st_q == chgh_pkg::I2C_TX) && $past(ptr_q) > `CHGH_R_FC
            |-> sh_q == 8'hFF;
    endproperty
    a_ff: assert property (p_ff) else $error("unmapped not ones");
    property p_cold;
        ts_en_q && cs_q.thermistor_fault_field == `CHGH_TS_COLDHOT
            |=> !ctrl_o.charge_enable;
    endproperty
    a_cold: assert property (p_cold) else $error("cold still charging");
endmodule

// [testbench/chgh_i2c_master.sv]
module chgh_i2c_master (
    output logic scl,
    output logic sda_lo,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic qclk = 1'b0;
    // quarter-bit tick; clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
        forever #8 qclk = ~qclk;
    end
    task automatic bit_io(input logic b, output logic s);
        @(posedge qclk) scl <= 1'b0;
        @(posedge qclk) sda_lo <= !b; // data moves only while clock low
        @(posedge qclk) scl <= 1'b1;
        @(posedge qclk) s = sda;
    endtask
    // msb first, then the receiver's acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                        output logic k);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(a, k);
    endtask
    task automatic start; // data falls while clock high
        @(posedge qclk) scl <= 1'b0;
        @(posedge qclk) sda_lo <= 1'b0;
        @(posedge qclk) scl <= 1'b1;
        @(posedge qclk) sda_lo <= 1'b1;
    endtask
    task automatic stop; // data rises while clock high, also after aborts
        @(posedge qclk) scl <= 1'b0;
        @(posedge qclk) sda_lo <= 1'b1;
        @(posedge qclk) scl <= 1'b1;
        @(posedge qclk) sda_lo <= 1'b0;
    endtask
    task automatic hold_low(input int n);
        @(posedge qclk) scl <= 1'b0;
        @(posedge qclk) sda_lo <= 1'b1;
        repeat (n) @(posedge qclk);
        sda_lo <= 1'b0;
    endtask
endmodule

// [testbench/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INT_CYC = 16;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, lfsr = 32'h0000_d292;
    logic pready, pslverr, scl, sda_lo, sda_o, sda_oe, int_n;
    wire sda;
    chgh_pkg::chgh_cond_t cond = '0;
    chgh_pkg::chgh_ctrl_t ctrl;
    logic [7:0] rb [4];
    int err_count = 0, cmp_count = 0;
    // open drain with pull-up: released means high
    assign sda = !(sda_oe | sda_lo);
    chgh_top #(.INT_CYC(INT_CYC), .HANG_CYC(200)) dut (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .cond_i(cond), .ctrl_o(ctrl), .int_n(int_n));
    chgh_i2c_master m (.scl(scl), .sda_lo(sda_lo), .sda(sda));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // {status code, ctrl mask, ctrl value} for one condition
    function automatic logic [21:0] exp_of(input logic [9:0] c);
        if (c[9] || c[8]) return {2'h3, 10'h3c0, 10'h040};
        if (c[7]) return {2'h1, 10'h104, 10'h104};
        if (c[6]) return {2'h3, 10'h020, 10'h020};
        if (c[5]) return {2'h3, 10'h180, 10'h000};
        if (c[4]) return {2'h3, 10'h002, 10'h002};
        if (c[1]) return {2'h2, 10'h101, 10'h001};
        if (c[3:2] == 2'h1) return {2'h3, 10'h100, 10'h000};
        if (c[3:2] == 2'h2) return {2'h3, 10'h010, 10'h010};
        return {2'h3, 10'h008, 10'h008};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sel(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic k;
        m.start();
        m.xfer(b, 1'b1, r, k);
        chk(k, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic k;
        sel(8'hd4, 1'b0);
        m.xfer(a, 1'b1, r, k);
        m.xfer(d, 1'b1, r, k);
        chk(k, 0);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        logic k;
        sel(8'hd4, 1'b0);
        m.xfer(a, 1'b1, r, k);
        m.start();
        m.xfer(8'hd5, 1'b1, r, k);
        chk(k, 0);
        for (int i = 0; i < n; i++) m.xfer(8'hff, i == n - 1, rb[i], k);
        m.stop();
    endtask
    task automatic pulse;
        int n = 0;
        for (int i = 0; i < 40 && int_n !== 1'b0; i++) @(negedge mclk);
        while (int_n === 1'b0 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk(n, INT_CYC);
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] v;
        logic [21:0] x;
        logic [9:0] cs [10] = '{10'h080, 10'h010, 10'h040, 10'h004, 10'h008, 10'h00c,
                                10'h002, 10'h200, 10'h020, 10'h100};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, 8'h00, 32'h0000_0000, r, e);
        chk({r[30:0], e}, 32'h0000_0f00);
        lfsr = nxt(lfsr);
        apb(1'b0, {lfsr[7:4] | 4'h1, 4'h0}, 32'h0000_0000, r, e);
        chk({r[30:0], e}, 32'h0000_0001);
        rd(8'h02, 2);
        chk({rb[0], rb[1]}, 32'h0000_8814);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            v = {lfsr[7:1], 1'b0};
            wr(8'h03, v);
            rd(8'h03, 1);
            chk(rb[0], v);
            rd(8'h00, 1);
            chk(rb[0][7:6], v[1] ? 2'h0 : 2'h1);
            rd({1'b1, lfsr[14:8]}, 1);
            chk(rb[0], 8'hff);
        end
        wr(8'h03, 8'h14);
        for (int b = 1; b < 8; b++) begin
            sel(8'hd4 ^ (8'h01 << b), 1'b1);
            m.stop();
        end
        foreach (cs[i]) begin
            @(posedge mclk) cond <= cs[i];
            x = exp_of(cs[i]);
            pulse();
            chk(ctrl & x[19:10], x[9:0]);
            rd(8'h00, 1);
            chk(rb[0][7:6], x[21:20]);
            @(posedge mclk) cond <= 10'h001;
            repeat (40) @(posedge mclk);
        end
        sel(8'hd4, 1'b0);
        m.hold_low(80);
        m.xfer(8'hd4, 1'b1, v, e);
        chk(e, 1);
        m.stop();
        wr(8'h00, 8'h20);
        sel(8'hd4, 1'b1);
        m.stop();
        apb(1'b1, 8'h04, 32'h0000_0001, r, e);
        sel(8'hd4, 1'b0);
        m.stop();
        wr(8'h03, 8'h15);
        sel(8'hd4, 1'b1);
        m.stop();
        print_verdict();
    end
    initial begin
        #400000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
